/* File: rtl/ub_pkg.sv */
package ub_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int UB_NSTG      = 4;
	localparam int UB_MAG_W     = 16;
	localparam int UB_TS_W      = 32;
	localparam int UB_SG_W      = 3;
	localparam int UB_EV_N      = 6;
	localparam int UB_LOG_DEPTH = 12;
	localparam int UB_LOG_AW    = 4;
	localparam int UB_ACC_W     = 48;

	// ----------------------------------------------------------------
	// pick-up hysteresis and timing
	// ----------------------------------------------------------------
	localparam logic [31:0] UB_HYST_NUM   = 32'h0000_0061;
	localparam logic [31:0] UB_HYST_DEN   = 32'h0000_0064;
	localparam logic [15:0] UB_REL_DEF_MS = 16'h003C;
	localparam logic [15:0] UB_REM_UNKN   = 16'hFFFF;
	localparam logic [15:0] UB_TIME_MAX   = 16'hFFFF;

	// ----------------------------------------------------------------
	// event codes, also the bit index inside a stage's event group
	// ----------------------------------------------------------------
	localparam logic [2:0] UB_EV_START_ON  = 3'h0;
	localparam logic [2:0] UB_EV_START_OFF = 3'h1;
	localparam logic [2:0] UB_EV_TRIP_ON   = 3'h2;
	localparam logic [2:0] UB_EV_TRIP_OFF  = 3'h3;
	localparam logic [2:0] UB_EV_BLK_ON    = 3'h4;
	localparam logic [2:0] UB_EV_BLK_OFF   = 3'h5;

	// ----------------------------------------------------------------
	// log record layout (lsb positions)
	// ----------------------------------------------------------------
	localparam int UB_RF_SG   = 0;
	localparam int UB_RF_REM  = 3;
	localparam int UB_RF_SEQ  = 19;
	localparam int UB_RF_PRE  = 115;
	localparam int UB_RF_FLT  = 131;
	localparam int UB_RF_PTR  = 147;
	localparam int UB_RF_TS   = 163;
	localparam int UB_RF_CODE = 195;
	localparam int UB_REC_W   = 198;

	// ----------------------------------------------------------------
	// modes and states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {UB_INSTANT, UB_DEFINITE, UB_INVERSE, UB_SQUARED} ub_mode_t;
	typedef enum logic [1:0] {UB_IEC, UB_IEEE, UB_USER} ub_curve_t;
	typedef enum logic {UB_REL_HOLD, UB_REL_RUN} ub_release_t;
	typedef enum logic [1:0] {UB_IDLE, UB_TIMING, UB_RELEASE, UB_TRIPPED} ub_state_t;

endpackage : ub_pkg

/* File: rtl/ub_log_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module ub_log_mem #(
	parameter int W     = 8,
	parameter int DEPTH = 12,
	parameter int AW    = 4
) (
	// clock
	input  wire logic          ref_clk,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// read port
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata_q
);

	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		rdata_q <= mem[raddr];
	end

endmodule : ub_log_mem
`default_nettype wire

/* File: rtl/ub_stage_block.sv */
// Contract
// - instant mode raises trip in the same cycle as start
// - definite mode trips after fixed delay of continuous pick-up
// - inverse delay depends on threshold and present measured magnitude
// - inverse offers IEC, IEEE/ANSI and user-parameter curves
// - squared curve: time equals k over measured squared minus threshold squared
// - release delay applies on drop, operating time frozen meanwhile
// - release-run option keeps operating timer advancing during release
// - release-run option trips only if pick-up returns before release expires
// - start, trip, blocked transitions give six on/off event codes
// - each event code has its own enable into the event buffer
// - four independent stages with distinct event source identity
// - triggering output stored with timestamp and process values
// - twelve most recent records kept circularly, oldest overwritten
// - records written only on start, trip or blocked on transitions
// - instant start and trip events share one millisecond timestamp
// - block at pick-up raises blocked, suppresses start, drops running start
// - pick-up releases below 97 percent of threshold
`timescale 1ns/10ps
`default_nettype none
module ub_stage_block
	import ub_pkg::*;
#(
	parameter int NSTG = UB_NSTG
) (
	// clock and reset
	input  wire logic                              ref_clk,
	input  wire logic                              resetn,
	// program cycle time base, one pulse per ms
	input  wire logic                              ms_tick,
	// measurements
	input  wire logic [UB_MAG_W-1:0]               measured_negative_sequence,
	input  wire logic [UB_MAG_W-1:0]               meas_pos_seq,
	input  wire logic [UB_MAG_W-1:0]               meas_zero_seq,
	input  wire logic [UB_MAG_W-1:0]               ang_pos_seq,
	input  wire logic [UB_MAG_W-1:0]               ang_neg_seq,
	input  wire logic [UB_MAG_W-1:0]               ang_zero_seq,
	input  wire logic [UB_MAG_W-1:0]               pretrig_mag,
	input  wire logic [UB_MAG_W-1:0]               prefault_mag,
	input  wire logic [UB_SG_W-1:0]                setting_group,
	// per-stage settings
	input  var  ub_mode_t                          set_mode    [NSTG],
	input  var  ub_curve_t                         set_curve   [NSTG],
	input  var  ub_release_t                       set_release [NSTG],
	input  wire logic [NSTG-1:0]                   set_exp2,
	input  wire logic [NSTG-1:0][UB_MAG_W-1:0]     set_thresh,
	input  wire logic [NSTG-1:0][15:0]             set_delay_ms,
	input  wire logic [NSTG-1:0][15:0]             set_rel_ms,
	input  wire logic [NSTG-1:0][31:0]             set_k,
	input  wire logic [NSTG-1:0][15:0]             set_curve_a,
	input  wire logic [NSTG-1:0][15:0]             set_curve_c,
	input  wire logic [NSTG-1:0][UB_EV_N-1:0]      ev_enable,
	// blocking matrix
	input  wire logic [NSTG-1:0]                   block_in,
	// stage outputs
	output logic      [NSTG-1:0]                   stg_start,
	output logic      [NSTG-1:0]                   stg_trip,
	output logic      [NSTG-1:0]                   stg_blocked,
	// event buffer
	output logic                                   ev_valid,
	input  wire logic                              ev_ready,
	output logic      [1:0]                        ev_stage,
	output logic      [2:0]                        ev_code,
	output logic      [UB_TS_W-1:0]                ev_time,
	output logic      [UB_TS_W-1:0]                ms_time,
	// record log
	input  wire logic [UB_LOG_AW-1:0]              log_rd_idx,
	output logic      [NSTG-1:0][UB_REC_W-1:0]     log_rd_data,
	output logic      [NSTG-1:0][UB_LOG_AW-1:0]    log_count
);

	localparam int EVT = NSTG * UB_EV_N;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] ub_first(input logic [EVT-1:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int b = EVT - 1; b >= 0; b--) begin
			if (v[b]) begin
				r = 5'(b);
			end
		end
		return r;
	endfunction : ub_first

	// ----------------------------------------------------------------
	// millisecond time base
	// ----------------------------------------------------------------
	logic [UB_TS_W-1:0] ms_time_q;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ms_time_q <= '0;
		end else if (ms_tick) begin
			ms_time_q <= ms_time_q + 32'h0000_0001;
		end
	end
	assign ms_time = ms_time_q;

	logic [EVT-1:0] ev_set;
	logic [NSTG-1:0][UB_TS_W-1:0] ev_ts_q;

	// ----------------------------------------------------------------
	// stages
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NSTG; i++) begin : g_stg
		ub_state_t            st_q;
		logic                 pk_q, start_q, trip_q, blk_q, pk_d, act, hit;
		logic                 st_p_q, tr_p_q, bl_p_q;
		logic [15:0]          el_q, el_n, rc_q, rem;
		logic [UB_ACC_W-1:0]  acc_q, acc_n, target;
		logic [31:0]          m, s, m2, s2, rate;
		logic [2:0]           lp_q;
		logic [UB_REC_W-1:0]  snap_q, wrec;
		logic [UB_LOG_AW-1:0] wp_q, cnt_q, ra;
		logic [4:0]           ra_t, lfirst;
		logic [2:0]           lsel;

		assign m  = {16'h0000, measured_negative_sequence};
		assign s  = {16'h0000, set_thresh[i]};
		assign m2 = m * m;
		assign s2 = s * s;
		// hysteresis: once up, hold until below 97 % of threshold
		assign pk_d = pk_q ? !(m * UB_HYST_DEN < s * UB_HYST_NUM) : (m >= s);
		assign act  = pk_d && !block_in[i];
		// rate of operate-progress per ms; zero below threshold
		assign rate = (m <= s) ? 32'h0000_0000
			: ((set_exp2[i] || set_mode[i] == UB_SQUARED) ? m2 - s2 : m - s);
		assign el_n = (el_q == UB_TIME_MAX) ? el_q : el_q + 16'h0001;
		assign acc_n = acc_q + {16'h0000, rate};
		assign target = (set_mode[i] == UB_SQUARED) ? {16'h0000, set_k[i]}
			: UB_ACC_W'(set_curve_a[i]) * UB_ACC_W'(set_exp2[i] ? s2 : s);

		always_comb begin
			case (set_mode[i])
				UB_INSTANT:  hit = 1'b1;
				UB_DEFINITE: hit = (el_n >= set_delay_ms[i]);
				// iec has no additive constant; ieee and user add a fixed minimum
				UB_INVERSE:  hit = (acc_n >= target)
					&& (set_curve[i] == UB_IEC || el_n >= set_curve_c[i]);
				UB_SQUARED:  hit = (acc_n >= target);
				default:     hit = 1'b0;
			endcase
		end

		always_comb begin
			if (trip_q) begin
				rem = 16'h0000;
			end else if (set_mode[i] == UB_DEFINITE) begin
				rem = (el_q >= set_delay_ms[i]) ? 16'h0000 : set_delay_ms[i] - el_q;
			end else if (set_mode[i] == UB_INSTANT) begin
				rem = 16'h0000;
			end else begin
				rem = UB_REM_UNKN;
			end
		end

		// block is sampled only on the program cycle tick
		always_ff @(posedge ref_clk) begin
			if (!resetn) begin
				st_q    <= UB_IDLE;
				pk_q    <= 1'b0;
				blk_q   <= 1'b0;
				start_q <= 1'b0;
				trip_q  <= 1'b0;
				el_q    <= '0;
				acc_q   <= '0;
				rc_q    <= '0;
			end else if (ms_tick) begin
				pk_q  <= pk_d;
				blk_q <= pk_d && block_in[i];
				case (st_q)
					UB_IDLE, UB_TIMING, UB_RELEASE: begin
						if (act) begin
							el_q    <= el_n;
							acc_q   <= acc_n;
							start_q <= 1'b1;
							trip_q  <= hit;
							st_q    <= hit ? UB_TRIPPED : UB_TIMING;
						end else if (st_q == UB_IDLE) begin
							st_q <= UB_IDLE;
						end else if (set_rel_ms[i] == 16'h0000
							|| (st_q == UB_RELEASE && rc_q >= set_rel_ms[i])) begin
							st_q    <= UB_IDLE;
							start_q <= 1'b0;
							el_q    <= '0;
							acc_q   <= '0;
						end else begin
							start_q <= 1'b0;
							st_q    <= UB_RELEASE;
							rc_q    <= (st_q == UB_TIMING) ? 16'h0001 : rc_q + 16'h0001;
							if (set_release[i] == UB_REL_RUN) begin
								el_q  <= el_n;
								acc_q <= acc_n;
							end
						end
					end
					UB_TRIPPED: begin
						if (!act) begin
							st_q    <= UB_IDLE;
							start_q <= 1'b0;
							trip_q  <= 1'b0;
							el_q    <= '0;
							acc_q   <= '0;
						end
					end
					default: st_q <= UB_IDLE;
				endcase
			end
		end

		assign stg_start[i]   = start_q;
		assign stg_trip[i]    = trip_q;
		assign stg_blocked[i] = blk_q;

		// ------------------------------------------------------------
		// transitions, events and record snapshot
		// ------------------------------------------------------------
		always_ff @(posedge ref_clk) begin
			if (!resetn) begin
				st_p_q <= 1'b0;
				tr_p_q <= 1'b0;
				bl_p_q <= 1'b0;
			end else begin
				st_p_q <= start_q;
				tr_p_q <= trip_q;
				bl_p_q <= blk_q;
			end
		end

		// stage i owns event bits [6i +: 6] so its source stays distinct
		assign ev_set[i*UB_EV_N +: UB_EV_N] = ev_enable[i] & {
			bl_p_q & !blk_q, !bl_p_q & blk_q,
			tr_p_q & !trip_q, !tr_p_q & trip_q,
			st_p_q & !start_q, !st_p_q & start_q};

		// start and trip from one tick share the stamp of that tick
		always_ff @(posedge ref_clk) begin
			if (!resetn) begin
				ev_ts_q[i] <= '0;
				snap_q     <= '0;
			end else if ((st_p_q ^ start_q) | (tr_p_q ^ trip_q) | (bl_p_q ^ blk_q)) begin
				ev_ts_q[i]                   <= ms_time_q;
				snap_q[UB_RF_TS +: UB_TS_W]  <= ms_time_q;
				snap_q[UB_RF_PTR +: 16]      <= pretrig_mag;
				snap_q[UB_RF_FLT +: 16]      <= measured_negative_sequence;
				snap_q[UB_RF_PRE +: 16]      <= prefault_mag;
				snap_q[UB_RF_SEQ +: 96]      <= {meas_pos_seq, measured_negative_sequence,
					meas_zero_seq, ang_pos_seq, ang_neg_seq, ang_zero_seq};
				snap_q[UB_RF_REM +: 16]      <= rem;
				snap_q[UB_RF_SG +: UB_SG_W]  <= setting_group;
				snap_q[UB_RF_CODE +: 3]      <= 3'h0;
			end
		end

		// ------------------------------------------------------------
		// record log, one write per clock per pending on-transition
		// ------------------------------------------------------------
		assign lfirst = ub_first(EVT'(lp_q));
		assign lsel   = lfirst[2:0];
		always_comb begin
			wrec = snap_q;
			wrec[UB_RF_CODE +: 3] = (lsel == 3'h0) ? UB_EV_START_ON
				: (lsel == 3'h1) ? UB_EV_TRIP_ON : UB_EV_BLK_ON;
		end

		always_ff @(posedge ref_clk) begin
			if (!resetn) begin
				lp_q  <= '0;
				wp_q  <= '0;
				cnt_q <= '0;
			end else begin
				if (lp_q != 3'h0) begin
					wp_q  <= (wp_q == UB_LOG_AW'(UB_LOG_DEPTH - 1)) ? '0 : wp_q + 4'h1;
					cnt_q <= (cnt_q == UB_LOG_AW'(UB_LOG_DEPTH)) ? cnt_q : cnt_q + 4'h1;
				end
				// a new on-transition wins over the clear of the served bit
				lp_q <= (lp_q & ~(3'h1 << lsel))
					| {!bl_p_q & blk_q, !tr_p_q & trip_q, !st_p_q & start_q};
			end
		end

		// index 0 is the newest record
		assign ra_t = 5'(wp_q) + 5'(UB_LOG_DEPTH - 1) - 5'(log_rd_idx);
		assign ra   = (ra_t >= 5'(UB_LOG_DEPTH)) ? 4'(ra_t - 5'(UB_LOG_DEPTH)) : ra_t[3:0];
		assign log_count[i] = cnt_q;

		ub_log_mem #(.W(UB_REC_W), .DEPTH(UB_LOG_DEPTH), .AW(UB_LOG_AW)) u_log (
			.ref_clk (ref_clk),
			.we      (lp_q != 3'h0),
			.waddr   (wp_q),
			.wdata   (wrec),
			.raddr   (ra),
			.rdata_q (log_rd_data[i])
		);
	end

	// ----------------------------------------------------------------
	// event buffer output, one event per accepted handshake
	// ----------------------------------------------------------------
	logic [EVT-1:0] ev_pend_q;
	logic [4:0]     ev_sel;
	logic           ev_load;

	assign ev_sel  = ub_first(ev_pend_q);
	assign ev_load = (ev_pend_q != '0) && (!ev_valid || ev_ready);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ev_pend_q <= '0;
		end else begin
			ev_pend_q <= (ev_pend_q & ~(ev_load ? EVT'(1) << ev_sel : EVT'(0))) | ev_set;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ev_valid <= 1'b0;
			ev_stage <= '0;
			ev_code  <= '0;
			ev_time  <= '0;
		end else if (ev_load) begin
			ev_valid <= 1'b1;
			ev_stage <= 2'(ev_sel / 5'(UB_EV_N));
			ev_code  <= 3'(ev_sel % 5'(UB_EV_N));
			ev_time  <= ev_ts_q[ev_sel / 5'(UB_EV_N)];
		end else if (ev_ready) begin
			ev_valid <= 1'b0;
		end
	end

endmodule : ub_stage_block
`default_nettype wire

/* File: sim/ub_stage_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module ub_stage_assertions
	import ub_pkg::*;
#(
	parameter int NSTG = UB_NSTG
) (
	// clock and reset
	input wire logic                         ref_clk,
	input wire logic                         resetn,
	input wire logic                         ms_tick,
	// settings and blocking
	input var  ub_mode_t                     set_mode [NSTG],
	input wire logic [NSTG-1:0][UB_EV_N-1:0] ev_enable,
	input wire logic [NSTG-1:0]              block_in,
	// stage outputs
	input wire logic [NSTG-1:0]              stg_start,
	input wire logic [NSTG-1:0]              stg_trip,
	input wire logic [NSTG-1:0]              stg_blocked,
	// events and log
	input wire logic                         ev_valid,
	input wire logic                         ev_ready,
	input wire logic [1:0]                   ev_stage,
	input wire logic [2:0]                   ev_code,
	input wire logic [UB_TS_W-1:0]           ev_time,
	input wire logic [UB_TS_W-1:0]           ms_time,
	input wire logic [NSTG-1:0][UB_LOG_AW-1:0] log_count
);
	// ----------------------------------------------------------------
	// stage 0 is watched; the other stages share the same logic
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	hold_no_tick_a: assert property (!ms_tick |=> $stable({stg_start, stg_trip, stg_blocked}))
		else $error("stage outputs moved between ticks");
	time_step_a: assert property (ms_tick |=> ms_time == $past(ms_time) + 32'h1)
		else $error("ms time not stepped by one");
	inst_trip_a: assert property (set_mode[0] == UB_INSTANT && $rose(stg_start[0]) |-> $rose(stg_trip[0]))
		else $error("instant trip not with start");
	blk_clear_a: assert property (ms_tick && !block_in[0] |=> !stg_blocked[0])
		else $error("blocked without block input");
	blk_start_a: assert property (ms_tick && block_in[0] |=> !stg_start[0])
		else $error("start kept while blocked");
	trip_start_a: assert property (stg_trip[0] |-> stg_start[0])
		else $error("trip without start");
	ev_hold_a: assert property (ev_valid && !ev_ready |=> ev_valid && $stable({ev_stage, ev_code, ev_time}))
		else $error("event changed before taken");
	ev_code_a: assert property (ev_valid |-> ev_code <= UB_EV_BLK_OFF)
		else $error("event code out of range");
	ev_trip_a: assert property ($rose(stg_trip[0]) && ev_enable[0][2] |-> ##[1:200] ev_valid && ev_code == UB_EV_TRIP_ON && ev_stage == 2'h0)
		else $error("trip event not issued");
	log_step_a: assert property ($past(resetn) && log_count[0] != $past(log_count[0]) |-> log_count[0] == $past(log_count[0]) + 4'h1)
		else $error("log count jumped");
	log_cap_a: assert property (log_count[0] <= 4'hC)
		else $error("log count above depth");

	cover property ($rose(stg_trip[0]));
	cover property (ev_valid && ev_ready);
	cover property (log_count[0] == 4'hC);
endmodule : ub_stage_assertions

bind ub_stage_block ub_stage_assertions #(.NSTG(NSTG)) ub_stage_assertions_i (.ref_clk, .resetn,
	.ms_tick, .set_mode, .ev_enable, .block_in, .stg_start, .stg_trip, .stg_blocked, .ev_valid,
	.ev_ready, .ev_stage, .ev_code, .ev_time, .ms_time, .log_count);
`default_nettype wire

/* File: sim/ub_ebm.sv */
`timescale 1ns/10ps
`default_nettype none
module ub_ebm (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// pacing
	input  wire logic        slow,
	// event port
	input  wire logic        ev_valid,
	input  wire logic [1:0]  ev_stage,
	input  wire logic [2:0]  ev_code,
	input  wire logic [31:0] ev_time,
	output logic             ev_ready
);
	logic [1:0]  qs [$];
	logic [2:0]  qc [$];
	logic [31:0] qt [$];
	// slow stalls every other cycle so events queue up in the block
	always @(posedge ref_clk) begin
		if (!resetn) begin
			ev_ready <= 1'b0;
		end else begin
			if (ev_valid && ev_ready) begin
				qs.push_back(ev_stage);
				qc.push_back(ev_code);
				qt.push_back(ev_time);
			end
			ev_ready <= slow ? !ev_ready : 1'b1;
		end
	end
endmodule : ub_ebm
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import ub_pkg::*;
	// ----------------------------------------------------------------
	// stimulus and observation
	// ----------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic ms_tick = 1'b0;
	logic slow = 1'b0;
	logic ev_valid, ev_ready;
	logic [15:0] i2 = 16'h0000;
	logic [15:0] aux = 16'h1234;
	logic [2:0] sg = 3'h5;
	ub_mode_t md [4];
	ub_curve_t cv [4];
	ub_release_t rl [4];
	logic [3:0] e2 = 4'h0;
	logic [3:0] blk = 4'h0;
	logic [3:0] idx = 4'h0;
	logic [3:0] st, tr, bl;
	logic [3:0][15:0] th, dl, rel, ca, cc;
	logic [3:0][31:0] k;
	logic [3:0][5:0] en;
	logic [1:0] evs;
	logic [2:0] evc;
	logic [31:0] evt, mst;
	logic [3:0][197:0] lrd;
	logic [3:0][3:0] lcnt;
	int fail_count = 0;
	int n_compared = 0;

	ub_stage_block ub_stage_block_i (.ref_clk, .resetn, .ms_tick, .measured_negative_sequence(i2),
		.meas_pos_seq(aux), .meas_zero_seq(aux), .ang_pos_seq(aux), .ang_neg_seq(aux),
		.ang_zero_seq(aux), .pretrig_mag(aux), .prefault_mag(aux), .setting_group(sg),
		.set_mode(md), .set_curve(cv), .set_release(rl), .set_exp2(e2), .set_thresh(th),
		.set_delay_ms(dl), .set_rel_ms(rel), .set_k(k), .set_curve_a(ca), .set_curve_c(cc),
		.ev_enable(en), .block_in(blk), .stg_start(st), .stg_trip(tr), .stg_blocked(bl),
		.ev_valid, .ev_ready, .ev_stage(evs), .ev_code(evc), .ev_time(evt), .ms_time(mst),
		.log_rd_idx(idx), .log_rd_data(lrd), .log_count(lcnt));
	ub_ebm ub_ebm_i (.ref_clk, .resetn, .slow, .ev_valid, .ev_stage(evs), .ev_code(evc),
		.ev_time(evt), .ev_ready);

	always #4 ref_clk = ~ref_clk;

	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk
	// ticks 32 clocks apart leave room for event drain and log writes
	task automatic tk(int n);
		repeat (n) begin
			@(posedge ref_clk) #1 ms_tick = 1'b1;
			@(posedge ref_clk) #1 ms_tick = 1'b0;
			repeat (30) @(posedge ref_clk);
			#1;
		end
	endtask : tk
	task automatic so(logic s, logic t);
		chk("start", st[0], s);
		chk("trip", tr[0], t);
	endtask : so
	task automatic cfg(ub_mode_t m, logic [15:0] t, logic [15:0] d);
		i2 = 16'h0000;
		rel[0] = 16'h0000;
		rl[0] = UB_REL_HOLD;
		blk = 4'h0;
		tk(2);
		md[0] = m;
		th[0] = t;
		dl[0] = d;
	endtask : cfg

	task automatic t_inst;
		cfg(UB_INSTANT, 16'h0064, 16'h0000);
		md[3] = UB_INSTANT;
		th[3] = 16'h0064;
		slow = 1'b1;
		i2 = 16'h00C8;
		tk(1);
		so(1'b1, 1'b1);
		chk("ev n", ub_ebm_i.qc.size(), 4);
		chk("ev code", ub_ebm_i.qc[1], UB_EV_TRIP_ON);
		chk("ev time", ub_ebm_i.qt[1], ub_ebm_i.qt[0]);
		chk("ev now", ub_ebm_i.qt[0], mst);
		chk("ev stage", ub_ebm_i.qs[2], 2'h3);
		chk("log n", lcnt[0], 4'h2);
		chk("log code", lrd[0][197:195], UB_EV_TRIP_ON);
		chk("log time", lrd[0][194:163], ub_ebm_i.qt[0]);
		chk("log cur", lrd[0][146:131], i2);
		chk("log pre", lrd[0][130:115], aux);
		chk("log rem", lrd[0][18:3], 16'h0000);
		chk("log sg", lrd[0][2:0], sg);
		en[0][UB_EV_START_OFF] = 1'b0;
		i2 = 16'h0000;
		tk(1);
		so(1'b0, 1'b0);
		chk("ev off n", ub_ebm_i.qc.size(), 7);
		chk("log off", lcnt[0], 4'h2);
		en[0] = 6'h3F;
		md[3] = UB_DEFINITE;
		th[3] = 16'hFFFF;
		repeat (6) begin
			i2 = 16'h00C8;
			tk(1);
			i2 = 16'h0000;
			tk(1);
		end
		chk("log full", lcnt[0], 4'hC);
		idx = 4'hB;
		repeat (2) @(posedge ref_clk);
		#1;
		chk("log oldest", lrd[0][197:195], UB_EV_START_ON);
		idx = 4'h0;
		$display("instant test done");
	endtask : t_inst

	task automatic t_dt_hyst;
		cfg(UB_DEFINITE, 16'h0064, 16'h0005);
		i2 = 16'h00C8;
		tk(4);
		so(1'b1, 1'b0);
		chk("log rem", lrd[0][18:3], 16'h0004);
		tk(1);
		so(1'b1, 1'b1);
		cfg(UB_DEFINITE, 16'h0064, 16'h03E8);
		i2 = 16'h0063;
		tk(1);
		so(1'b0, 1'b0);
		i2 = 16'h0064;
		tk(1);
		so(1'b1, 1'b0);
		i2 = 16'h0061;
		tk(1);
		so(1'b1, 1'b0);
		i2 = 16'h0060;
		tk(1);
		so(1'b0, 1'b0);
		$display("definite and hysteresis test done");
	endtask : t_dt_hyst

	task automatic t_rel;
		for (int r = 0; r < 3; r++) begin
			cfg(UB_DEFINITE, 16'h0064, 16'h0007);
			rel[0] = 16'h0005;
			rl[0] = (r == 0) ? UB_REL_HOLD : UB_REL_RUN;
			i2 = 16'h00C8;
			tk(3);
			i2 = 16'h0000;
			tk(r == 2 ? 4 : 2);
			so(1'b0, 1'b0);
			i2 = 16'h00C8;
			tk(1);
			so(1'b1, r == 2);
			tk(2);
			so(1'b1, r != 0);
		end
		$display("release test done");
	endtask : t_rel

	task automatic t_blk;
		cfg(UB_DEFINITE, 16'h0064, 16'h03E8);
		i2 = 16'h00C8;
		blk[0] = 1'b1;
		tk(1);
		so(1'b0, 1'b0);
		chk("blocked", bl[0], 1'b1);
		chk("log blk", lrd[0][197:195], UB_EV_BLK_ON);
		blk[0] = 1'b0;
		tk(1);
		so(1'b1, 1'b0);
		chk("unblocked", bl[0], 1'b0);
		blk[0] = 1'b1;
		tk(1);
		so(1'b0, 1'b0);
		chk("reblocked", bl[0], 1'b1);
		$display("blocking test done");
	endtask : t_blk

	task automatic t_curves;
		ub_mode_t mm [6] = '{UB_INVERSE, UB_INVERSE, UB_INVERSE, UB_INVERSE, UB_INVERSE, UB_SQUARED};
		ub_curve_t c [6] = '{UB_IEC, UB_IEEE, UB_USER, UB_IEC, UB_IEC, UB_IEC};
		logic [15:0] m [6] = '{16'h0014, 16'h0014, 16'h0014, 16'h001E, 16'h0011, 16'h0014};
		int n [6] = '{3, 5, 5, 2, 2, 4};
		for (int j = 0; j < 6; j++) begin
			cfg(mm[j], 16'h000A, 16'h0000);
			cv[0] = c[j];
			e2[0] = (j == 4);
			k[0] = 32'h0000_04B0;
			i2 = m[j];
			tk(n[j] - 1);
			so(1'b1, 1'b0);
			tk(1);
			so(1'b1, 1'b1);
		end
		e2[0] = 1'b0;
		$display("curve test done");
	endtask : t_curves

	task automatic end_of_test;
		$display("compared %0d mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		#200000;
		fail_count++;
		end_of_test();
	end

	initial begin
		for (int s = 0; s < 4; s++) begin
			md[s] = UB_DEFINITE;
			cv[s] = UB_IEC;
			rl[s] = UB_REL_HOLD;
			th[s] = 16'hFFFF;
			dl[s] = 16'h0064;
			rel[s] = UB_REL_DEF_MS;
			k[s] = 32'h0000_1000;
			ca[s] = 16'h0003;
			cc[s] = 16'h0005;
			en[s] = 6'h3F;
		end
		repeat (20) @(posedge ref_clk);
		#1 resetn = 1'b1;
		t_inst();
		t_dt_hyst();
		t_rel();
		t_blk();
		t_curves();
		end_of_test();
	end
endmodule : tb
`default_nettype wire
